// ---- src/lad_consts.svh ----
`ifndef LAD_CONSTS_SVH
`define LAD_CONSTS_SVH
// register addresses
`define LAD_ADDR_STATE 8'hB9
`define LAD_ADDR_IRQEN 8'hBA
`define LAD_ADDR_FLAGS 8'hBB
`define LAD_ADDR_FLDTH 8'hBC
`define LAD_ADDR_FLCTH 8'hBD
`define LAD_ADDR_RMDTH 8'hBE
`define LAD_ADDR_RMCTH 8'hBF
`define LAD_ADDR_BLDTH 8'hC0
`define LAD_ADDR_BLCTH 8'hC1
`define LAD_ADDR_MODE 8'hC6
// bit positions inside state, enable and flag registers
`define LAD_BIT_FL 0
`define LAD_BIT_RM 1
`define LAD_BIT_BL 2
// threshold reset values
`define LAD_RST_FLDTH 8'h3F
`define LAD_RST_FLCTH 8'h7F
`define LAD_RST_RMDTH 8'h0A
`define LAD_RST_RMCTH 8'h0A
`define LAD_RST_BLDTH 8'h3F
`define LAD_RST_BLCTH 8'h3F
// count limits per window
`define LAD_BLUE_DECL_LT 16'h003D
`define LAD_SF_DECL_LT 16'h004D
`define LAD_DM_DECL_LT 16'h0004
`define LAD_J1SF_DECL_LT 16'h0004
`define LAD_ESF_DECL_GT 16'h0007
`define LAD_J1ESF_DECL_LT 16'h0003
`define LAD_ESF_PATTERN 16'hFF00
// timing
`define LAD_FRAME_NS 125000
`define LAD_WINDOW_NS 40000000
`define LAD_RED_CLR_WINDOWS 10'h003
`endif

// ---- src/lad_pkg.sv ----
`default_nettype none
package lad_pkg;
  // framing formats of the received line; T1 SF also covers SLC-96
  typedef enum logic [2:0] {
    LAD_T1SF = 3'h0,
    LAD_T1ESF = 3'h1,
    LAD_T1DM = 3'h2,
    LAD_J1SF = 3'h3,
    LAD_J1ESF = 3'h4
  } lad_mode_type;
endpackage
`default_nettype wire

// ---- src/lad_alarm_detector.sv ----
// Behaviour
// - blue set: under 61 zeros, N windows
// - blue clear: over 60 zeros, M windows
// - SF yellow set: under 77 ones, N windows
// - SF yellow clear: over 76 ones, M windows
// - ESF yellow set: over 7 FF00 patterns
// - ESF yellow clear: under 8 FF00 patterns
// - DM yellow set: under 4 Y ones
// - DM yellow clear: over 3 Y ones
// - J1 SF yellow set: under 4 zeros
// - J1 SF yellow clear: over 3 zeros
// - J1 ESF yellow set: under 3 zeros
// - J1 ESF yellow clear: over 2 zeros
// - yellow judged only while frame is synchronised
// - red set after N windows out of sync
// - red clear after M times 120 ms sync
// - change flag latches on any state change
// - flags cleared by writing one only
// - interrupt needs matching enable bit set
// - six separate 8-bit threshold registers
`timescale 1ns/1ps
`default_nettype none
`include "lad_consts.svh"

// persistence filter: declares or clears after a run of qualifying windows
module lad_persist #(
  parameter int CW = 10
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic winEnd, // one-cycle pulse at end of a window
  input wire logic active, // low holds state and restarts the run
  input wire logic declCond,
  input wire logic clrCond,
  input wire logic [CW-1:0] declThr,
  input wire logic [CW-1:0] clrThr,
  output logic alarm_r,
  output logic toggle // state changes at this edge
);
  logic [CW-1:0] run_r; // consecutive qualifying windows
  logic hit; // current window qualifies toward the other state
  logic [CW-1:0] thr;
  logic [CW-1:0] runInc;
  if (CW < 8) begin : gBadWidth // run counter must hold an 8-bit threshold
    $error("run counter narrower than a threshold");
  end

  // pick the condition and threshold that apply to the present state
  always_comb begin
    hit = alarm_r ? clrCond : declCond;
    thr = alarm_r ? clrThr : declThr;
    runInc = run_r + {{(CW-1){1'b0}}, 1'b1};
    // a zero threshold acts as one window
    toggle = active && winEnd && hit && (runInc >= thr);
  end

  // run counter restarts whenever the condition lapses
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      run_r <= '0;
    end else if (!active || toggle) begin
      run_r <= '0;
    end else if (winEnd) begin
      run_r <= hit ? runInc : '0;
    end
  end

  // alarm state, cleared by reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      alarm_r <= 1'b0;
    end else if (toggle) begin
      alarm_r <= !alarm_r;
    end
  end
endmodule

// receive alarm detector with its register file
module lad_alarm_detector #(
  parameter int FRAME_NS = `LAD_FRAME_NS,
  parameter int WINDOW_NS = `LAD_WINDOW_NS,
  parameter int FRAMES_PER_WINDOW = WINDOW_NS / FRAME_NS // 320 frames of 125 us
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] regAddr, // register address
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData_r, // valid the cycle after the read strobe
  input wire logic frameStb, // one pulse per received frame
  input wire logic inFrameSync, // framer reports frame synchronisation
  input wire logic lineBitValid, // pulse with every received line bit
  input wire logic lineBit,
  input wire logic remBitValid, // pulse on the bit the format watches
  output logic blue_alarm_state,
  output logic remote_alarm_state,
  output logic frame_loss_alarm_state,
  output logic irqN_r // interrupt, active low
);
  localparam int WCW = 16;
  if (FRAMES_PER_WINDOW < 2 || FRAMES_PER_WINDOW > 65535) begin : gBadWindow // frame counter is 16 bits
    $error("frames per window out of range");
  end

  // configuration registers
  logic [2:0] irqEn_r; // per-alarm enables
  logic [2:0] flags_r; // change flags
  logic [7:0] flDth_r; // frame_loss_declare_threshold
  logic [7:0] flCth_r; // frame_loss_clear_threshold
  logic [7:0] rmDth_r; // remote_declare_threshold
  logic [7:0] rmCth_r; // remote_clear_threshold
  logic [7:0] blDth_r; // blue_declare_threshold
  logic [7:0] blCth_r; // blue_clear_threshold
  lad_pkg::lad_mode_type mode_r; // framing format

  // window timing
  logic [WCW-1:0] frmCnt_r;
  logic winEnd;
  logic [WCW-1:0] zeroCnt_r; // all line zeros in window
  logic [WCW-1:0] remCnt_r; // yellow-relevant count in window
  logic [15:0] dlShift_r; // sliding data_link_bits
  logic lostSync_r; // sync dropped somewhere in window
  logic gotSync_r; // sync seen somewhere in window
  logic remCountBit; // watched bit counts for this format
  logic [15:0] dlShiftNxt;
  logic remDecl;
  logic remClr;
  logic [9:0] flClrWin;
  logic [2:0] toggles;
  logic wrFlags;

  // window ends on the last frame of each fixed window
  assign winEnd = frameStb && (frmCnt_r == WCW'(FRAMES_PER_WINDOW - 1));

  // frame counter across a fixed window
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      frmCnt_r <= '0;
    end else if (winEnd) begin
      frmCnt_r <= '0;
    end else if (frameStb) begin
      frmCnt_r <= frmCnt_r + {{(WCW-1){1'b0}}, 1'b1};
    end
  end

  // zero count over every received bit, saturating
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      zeroCnt_r <= '0;
    end else if (winEnd) begin
      zeroCnt_r <= '0;
    end else if (lineBitValid && !lineBit && zeroCnt_r != '1) begin
      zeroCnt_r <= zeroCnt_r + {{(WCW-1){1'b0}}, 1'b1};
    end
  end

  // what the watched bit contributes depends on the format
  always_comb begin
    dlShiftNxt = {dlShift_r[14:0], lineBit};
    case (mode_r)
      lad_pkg::LAD_T1SF: remCountBit = lineBit;
      lad_pkg::LAD_T1DM: remCountBit = lineBit;
      lad_pkg::LAD_T1ESF: remCountBit = (dlShiftNxt == `LAD_ESF_PATTERN);
      lad_pkg::LAD_J1SF: remCountBit = !lineBit;
      lad_pkg::LAD_J1ESF: remCountBit = !lineBit;
      default: remCountBit = 1'b0;
    endcase
  end

  // sliding shift of data-link bits, msb first
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dlShift_r <= '0;
    end else if (remBitValid) begin
      dlShift_r <= dlShiftNxt;
    end
  end

  // yellow count per window, saturating
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      remCnt_r <= '0;
    end else if (winEnd) begin
      remCnt_r <= '0;
    end else if (remBitValid && remCountBit && remCnt_r != '1) begin
      remCnt_r <= remCnt_r + {{(WCW-1){1'b0}}, 1'b1};
    end
  end

  // sync history of the present window
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lostSync_r <= 1'b0;
      gotSync_r <= 1'b0;
    end else if (winEnd) begin
      // the sample at the window end belongs to the closing window, so history restarts empty
      lostSync_r <= 1'b0;
      gotSync_r <= 1'b0;
    end else begin
      lostSync_r <= lostSync_r || !inFrameSync;
      gotSync_r <= gotSync_r || inFrameSync;
    end
  end

  // yellow window verdicts per format
  always_comb begin
    case (mode_r)
      lad_pkg::LAD_T1SF: begin
        remDecl = remCnt_r < `LAD_SF_DECL_LT;
        remClr = !remDecl;
      end
      lad_pkg::LAD_T1ESF: begin
        remDecl = remCnt_r > `LAD_ESF_DECL_GT;
        remClr = !remDecl;
      end
      lad_pkg::LAD_T1DM: begin
        remDecl = remCnt_r < `LAD_DM_DECL_LT;
        remClr = !remDecl;
      end
      lad_pkg::LAD_J1SF: begin
        remDecl = remCnt_r < `LAD_J1SF_DECL_LT;
        remClr = !remDecl;
      end
      lad_pkg::LAD_J1ESF: begin
        remDecl = remCnt_r < `LAD_J1ESF_DECL_LT;
        remClr = !remDecl;
      end
      default: begin
        remDecl = 1'b0;
        remClr = 1'b0;
      end
    endcase
  end

  // red clear counts 120 ms as three windows
  assign flClrWin = 10'(flCth_r) * `LAD_RED_CLR_WINDOWS;

  // blue alarm filter
  lad_persist #(.CW(10)) uBlue (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .winEnd(winEnd),
    .active(1'b1),
    .declCond(zeroCnt_r < `LAD_BLUE_DECL_LT),
    .clrCond(zeroCnt_r >= `LAD_BLUE_DECL_LT),
    .declThr({2'b00, blDth_r}),
    .clrThr({2'b00, blCth_r}),
    .alarm_r(blue_alarm_state),
    .toggle(toggles[`LAD_BIT_BL])
  );

  // yellow alarm filter, frozen while out of frame
  lad_persist #(.CW(10)) uRemote (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .winEnd(winEnd),
    .active(inFrameSync && !lostSync_r),
    .declCond(remDecl),
    .clrCond(remClr),
    .declThr({2'b00, rmDth_r}),
    .clrThr({2'b00, rmCth_r}),
    .alarm_r(remote_alarm_state),
    .toggle(toggles[`LAD_BIT_RM])
  );

  // red alarm filter on whole windows in or out of sync
  lad_persist #(.CW(10)) uFrameLoss (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .winEnd(winEnd),
    .active(1'b1),
    .declCond(!gotSync_r && !inFrameSync),
    .clrCond(!lostSync_r && inFrameSync),
    .declThr({2'b00, flDth_r}),
    .clrThr(flClrWin),
    .alarm_r(frame_loss_alarm_state),
    .toggle(toggles[`LAD_BIT_FL])
  );

  assign wrFlags = regWrStb && (regAddr == `LAD_ADDR_FLAGS);

  // change flags: set on any toggle, write one clears, set wins
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flags_r <= '0;
    end else begin
      flags_r <= toggles | (flags_r & ~(wrFlags ? regWrData[2:0] : 3'h0));
    end
  end

  // writable configuration registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irqEn_r <= '0;
      flDth_r <= `LAD_RST_FLDTH;
      flCth_r <= `LAD_RST_FLCTH;
      rmDth_r <= `LAD_RST_RMDTH;
      rmCth_r <= `LAD_RST_RMCTH;
      blDth_r <= `LAD_RST_BLDTH;
      blCth_r <= `LAD_RST_BLCTH;
      mode_r <= lad_pkg::LAD_T1SF;
    end else if (regWrStb) begin
      case (regAddr)
        `LAD_ADDR_IRQEN: irqEn_r <= regWrData[2:0];
        `LAD_ADDR_FLDTH: flDth_r <= regWrData;
        `LAD_ADDR_FLCTH: flCth_r <= regWrData;
        `LAD_ADDR_RMDTH: rmDth_r <= regWrData;
        `LAD_ADDR_RMCTH: rmCth_r <= regWrData;
        `LAD_ADDR_BLDTH: blDth_r <= regWrData;
        `LAD_ADDR_BLCTH: blCth_r <= regWrData;
        `LAD_ADDR_MODE: mode_r <= lad_pkg::lad_mode_type'(regWrData[2:0]);
        default: ;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      regRdData_r <= '0;
    end else if (regRdStb) begin
      case (regAddr)
        `LAD_ADDR_STATE: regRdData_r <= {5'h00, blue_alarm_state, remote_alarm_state, frame_loss_alarm_state};
        `LAD_ADDR_IRQEN: regRdData_r <= {5'h00, irqEn_r};
        `LAD_ADDR_FLAGS: regRdData_r <= {5'h00, flags_r};
        `LAD_ADDR_FLDTH: regRdData_r <= flDth_r;
        `LAD_ADDR_FLCTH: regRdData_r <= flCth_r;
        `LAD_ADDR_RMDTH: regRdData_r <= rmDth_r;
        `LAD_ADDR_RMCTH: regRdData_r <= rmCth_r;
        `LAD_ADDR_BLDTH: regRdData_r <= blDth_r;
        `LAD_ADDR_BLCTH: regRdData_r <= blCth_r;
        `LAD_ADDR_MODE: regRdData_r <= {5'h00, mode_r};
        default: regRdData_r <= 8'h00;
      endcase
    end else begin
      regRdData_r <= 8'h00;
    end
  end

  // interrupt from enabled flags, registered
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irqN_r <= 1'b1;
    end else begin
      irqN_r <= !(|(flags_r & irqEn_r));
    end
  end

  // checks
  sequence sWinClosed;
    $past(winEnd);
  endsequence
  sequence sFlagWriteOne;
    wrFlags && regWrData[`LAD_BIT_BL] && !toggles[`LAD_BIT_BL];
  endsequence

  AST_BLUE_SET_AT_WINDOW: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(blue_alarm_state) |-> sWinClosed and $past(zeroCnt_r) < `LAD_BLUE_DECL_LT)
    else $error("blue set away from a quiet window end");

  AST_BLUE_CLR_AT_WINDOW: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(blue_alarm_state) |-> sWinClosed and $past(zeroCnt_r) >= `LAD_BLUE_DECL_LT)
    else $error("blue cleared away from a busy window end");

  AST_REMOTE_FROZEN_OOF: assert property (@(posedge clk_sys) disable iff (!rstn)
    !$past(inFrameSync) |-> $stable(remote_alarm_state))
    else $error("yellow changed while out of frame");

  AST_RED_SET_OOF: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(frame_loss_alarm_state) |-> sWinClosed and !$past(inFrameSync))
    else $error("red set while in sync");

  AST_RED_CLR_SYNC: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(frame_loss_alarm_state) |-> sWinClosed and $past(inFrameSync))
    else $error("red cleared while out of sync");

  AST_FLAG_ON_CHANGE: assert property (@(posedge clk_sys) disable iff (!rstn)
    !($changed(blue_alarm_state) && !flags_r[`LAD_BIT_BL]) &&
      !($changed(frame_loss_alarm_state) && !flags_r[`LAD_BIT_FL]))
    else $error("state change without change flag");
  AST_FLAG_ON_REMOTE: assert property (@(posedge clk_sys) disable iff (!rstn)
    $changed(remote_alarm_state) |-> flags_r[`LAD_BIT_RM])
    else $error("yellow change without change flag");

  AST_FLAG_W1C: assert property (@(posedge clk_sys) disable iff (!rstn)
    sFlagWriteOne |=> !flags_r[`LAD_BIT_BL])
    else $error("write one did not clear flag");

  AST_FLAG_W0_KEEPS: assert property (@(posedge clk_sys) disable iff (!rstn)
    wrFlags |=> (($past(flags_r) & ~$past(regWrData[2:0]) & ~flags_r) == 3'h0))
    else $error("write zero cleared flag");

  AST_IRQ_GATED: assert property (@(posedge clk_sys) disable iff (!rstn)
    ##1 irqN_r == !(|($past(flags_r) & $past(irqEn_r))))
    else $error("interrupt does not follow enabled flags");
endmodule

`default_nettype wire

// ---- testbench/lad_line_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// far-end terminal: frames of 64 cycles carrying 48 line bits, pattern sent msb first
module lad_line_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [15:0] pat, // repeating line pattern
  input wire logic watch, // mark every line bit as the watched bit
  input wire logic syncIn, // sync level the framer reports
  output logic frameStb,
  output logic lineBitValid,
  output logic lineBit,
  output logic remBitValid,
  output logic inFrameSync
);
  logic [5:0] slot_r; // cycle inside the frame
  logic [3:0] idx_r; // pattern position, runs on across frames
  logic bitNow; // a line bit is launched at this edge
  assign bitNow = (slot_r != 6'h00) && (slot_r <= 6'h30);
  assign inFrameSync = syncIn;
  // strobe in slot 0, bits only after it, so a pattern set at the strobe edge fills a whole window
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      slot_r <= 6'h00;
      idx_r <= 4'h0;
      frameStb <= 1'b0;
      lineBitValid <= 1'b0;
      remBitValid <= 1'b0;
      lineBit <= 1'b0;
    end else begin
      slot_r <= slot_r + 6'h01;
      frameStb <= (slot_r == 6'h3F);
      lineBitValid <= bitNow;
      remBitValid <= bitNow && watch;
      if (bitNow) begin
        lineBit <= pat[4'hF - idx_r];
        idx_r <= idx_r + 4'h1;
      end else begin
        // idle line toggles so a stale bit never reads as data
        lineBit <= ~lineBit;
      end
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "lad_consts.svh"
module tb;
  logic clk_sys = 1'b0; // 40 MHz system clock
  logic rstn; // active low reset
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [7:0] regRdData_r;
  logic frameStb, inFrameSync, lineBitValid, lineBit, remBitValid;
  logic blueSt, remoteSt, lossSt, irqN_r; // alarm outputs
  logic [15:0] pat = 16'hFF00; // quiet pattern in every alarm except T1 ESF yellow, which it declares
  logic syncIn = 1'b1;
  int frameCount = 0; // frame strobes since reset
  int bad_count = 0;
  int samples_checked = 0;
  logic [7:0] rv; // last read value
  // yellow declare and clear patterns per framing mode
  logic [15:0] declPat [5] = '{16'h0000, 16'hFF00, 16'h0000, 16'hFFFF, 16'hFFFF};
  logic [15:0] clrPat [5] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000};
  // register reset table, last entry unmapped
  logic [7:0] rstAddr [11] = '{8'hB9, 8'hBA, 8'hBB, 8'hBC, 8'hBD, 8'hBE, 8'hBF, 8'hC0, 8'hC1, 8'hC6, 8'hC7};
  logic [7:0] rstVal [11] = '{8'h00, 8'h00, 8'h00, 8'h3F, 8'h7F, 8'h0A, 8'h0A, 8'h3F, 8'h3F, 8'h00, 8'h00};

  lad_alarm_detector #(.FRAMES_PER_WINDOW(4)) i_lad_alarm_detector (
    .clk_sys(clk_sys), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdData_r(regRdData_r), .frameStb(frameStb), .inFrameSync(inFrameSync),
    .lineBitValid(lineBitValid), .lineBit(lineBit), .remBitValid(remBitValid),
    .blue_alarm_state(blueSt), .remote_alarm_state(remoteSt), .frame_loss_alarm_state(lossSt), .irqN_r(irqN_r));
  lad_line_model i_lad_line_model (
    .clk_sys(clk_sys), .rstn(rstn), .pat(pat), .watch(1'b1), .syncIn(syncIn), .frameStb(frameStb),
    .lineBitValid(lineBitValid), .lineBit(lineBit), .remBitValid(remBitValid), .inFrameSync(inFrameSync));

  // clock generator
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // count frames as the design does, to find window ends
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      frameCount <= 0;
    end else if (frameStb === 1'b1) begin
      frameCount <= frameCount + 1;
    end
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // alarm states in register order: blue, remote, frame loss
  task automatic chks(input logic [2:0] mask, input logic [2:0] exp);
    #1;
    chk("alarm state", {5'h00, {blueSt, remoteSt, lossSt} & mask}, {5'h00, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk_sys);
    regWrStb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    #1 d = regRdData_r;
  endtask
  task automatic settle;
    @(posedge clk_sys);
    #1;
  endtask
  // returns on the edge that ends the n-th window from now
  task automatic wait_win(input int n);
    int k;
    for (int w = 0; w < n; w++) begin
      k = 0;
      do begin
        @(posedge clk_sys);
        k++;
      end while (!(frameStb === 1'b1 && frameCount % 4 == 3) && k < 400);
      if (k >= 400) begin
        bad_count++;
        end_sim();
      end
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    rstn <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    settle();
    chk("irq idle", {7'h00, irqN_r}, 8'h01);
    for (int i = 0; i < 11; i++) begin
      rd(rstAddr[i], rv);
      chk("reset value", rv, rstVal[i]);
    end
    settle();
    chk("read idle", regRdData_r, 8'h00);
    wr(`LAD_ADDR_STATE, 8'hFF);
    rd(`LAD_ADDR_STATE, rv);
    chk("state read only", rv, 8'h00);
    // each threshold is its own register; then all set to 2, two windows but six for red clear
    for (int a = `LAD_ADDR_FLDTH; a <= `LAD_ADDR_BLCTH; a++) begin
      wr(8'(a), 8'(a));
      rd(8'(a), rv);
      chk("threshold", rv, 8'(a));
      wr(8'(a), 8'h02);
    end
    // blue: exactly 60 zeros per window declares
    wait_win(1);
    pat <= 16'h07FF;
    wait_win(1);
    chks(3'h4, 3'h0);
    wait_win(1);
    chks(3'h4, 3'h4);
    rd(`LAD_ADDR_FLAGS, rv);
    chk("blue flag", rv, 8'h04);
    chk("irq masked", {7'h00, irqN_r}, 8'h01);
    wr(`LAD_ADDR_FLAGS, 8'h00);
    rd(`LAD_ADDR_FLAGS, rv);
    chk("flag kept", rv, 8'h04);
    wr(`LAD_ADDR_IRQEN, 8'h04);
    rd(`LAD_ADDR_IRQEN, rv);
    chk("enables", rv, 8'h04);
    settle();
    chk("irq raised", {7'h00, irqN_r}, 8'h00);
    wr(`LAD_ADDR_FLAGS, 8'h04);
    settle();
    chk("irq cleared", {7'h00, irqN_r}, 8'h01);
    // blue clear with a lapse that restarts the run
    wait_win(1);
    pat <= 16'hFF00;
    wait_win(1);
    pat <= 16'h07FF;
    chks(3'h4, 3'h4);
    wait_win(1);
    pat <= 16'hFF00;
    wait_win(1);
    chks(3'h4, 3'h4);
    wait_win(1);
    chks(3'h4, 3'h0);
    rd(`LAD_ADDR_FLAGS, rv);
    chk("blue flag fall", rv, 8'h04);
    // yellow in every framing mode
    for (int m = 0; m < 5; m++) begin
      wait_win(1);
      pat <= clrPat[m];
      wr(`LAD_ADDR_MODE, 8'(m));
      wait_win(1);
      pat <= declPat[m];
      wait_win(1);
      chks(3'h2, 3'h0);
      wait_win(1);
      pat <= clrPat[m];
      chks(3'h2, 3'h2);
      wait_win(1);
      chks(3'h2, 3'h2);
      wait_win(1);
      chks(3'h2, 3'h0);
    end
    rd(`LAD_ADDR_FLAGS, rv);
    chk("remote flag", rv & 8'h02, 8'h02);
    // frame loss; yellow declare pattern stays frozen while out of sync
    wr(`LAD_ADDR_MODE, {5'h00, lad_pkg::LAD_T1SF});
    wr(`LAD_ADDR_FLAGS, 8'h07);
    wait_win(1);
    syncIn <= 1'b0;
    wait_win(1);
    chks(3'h1, 3'h0);
    wait_win(2);
    syncIn <= 1'b1;
    chks(3'h3, 3'h1);
    rd(`LAD_ADDR_FLAGS, rv);
    chk("loss flag only", rv, 8'h01);
    wait_win(5);
    chks(3'h1, 3'h1);
    wait_win(1);
    chks(3'h1, 3'h0);
    end_sim();
  end
endmodule
`default_nettype wire
